// ---- design/rst_boot_map.svh ----
// constants for the reset sequencer and boot vector selection
`ifndef RST_BOOT_MAP_SVH
`define RST_BOOT_MAP_SVH
`define BOOT_MARKER_PRESENT   8'hA5
`define RESET_VECTOR          16'h0000
`define BOOT_VECTOR_DEFAULT   16'h7C00
`define FLASH_LAST_PAGE_BASE  16'h7C00
`define LOCK_BYTE_ADDR        16'h7FFF
`define MARKER_ADDR           16'h7FFE
`define FLASH_READ_LAT        4'h2
`define SRC_POR               3'h0
`define SRC_PIN               3'h1
`define SRC_CMP               3'h2
`define SRC_SW                3'h3
`define SRC_VMON              3'h4
`define SRC_WDT               3'h5
`define SRC_MCD               3'h6
`define SRC_FLASH             3'h7
`define NUM_SRC               8
`define CAUSE_AFTER_RST       8'h01
`endif

// ---- design/rst_boot_pkg.sv ----
// types for the reset sequencer and boot vector selection
package rst_boot_pkg;
    typedef struct packed {
        logic flash_err;
        logic clk_missing;
        logic wdt_ovf;
        logic vdd_low;
        logic sw_req;
        logic cmp_trip;
        logic pin_low;
        logic por;
    } reset_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] vector;
        logic        boot_sel;
    } start_info_t;

    typedef enum logic [2:0] {
        ST_IN_RESET,
        ST_MARKER_REQ,
        ST_MARKER_WAIT,
        ST_RUN
    } seq_state_t;
endpackage

// ---- design/reset_sync.sv ----
// two flip-flop synchroniser for asynchronous level inputs
module reset_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk, // system clock
    input  wire logic             rst,     // async reset, active high
    input  wire logic [WIDTH-1:0] async_in, // level from outside the domain
    output logic      [WIDTH-1:0] sync_out  // synchronised level
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// ---- design/reset_boot_vector_select.sv ----
// reset entry/exit sequencer with flash marker driven start vector selection
// How it works
// - low supply, low reset pin or any enabled source puts the device in reset.
// - sources are por, pin, comparator, software, supply, watchdog, clock, flash.
// - in reset, core is halted and registers and pins forced to defaults.
// - leaving reset, the pc clears so execution starts at 0x0000 unless redirected.
// - boot program lives in the last flash page, which stays erasable.
// - byte before the lock byte is the marker; 0xA5 means bootloader present.
// - any other marker value means no bootloader.
// - with bootloader present, start at the boot vector after every reset.
// - without bootloader, start at 0x0000 after every reset.
// - the bootloader itself chooses to stay or jump to 0x0000.
`include "rst_boot_map.svh"

module reset_boot_vector_select #(
    parameter logic [15:0] BOOT_VECTOR = `BOOT_VECTOR_DEFAULT,
    parameter logic [15:0] MARKER_ADDR = `MARKER_ADDR,
    parameter logic [3:0]  READ_LAT    = `FLASH_READ_LAT
) (
    input  wire logic                     ref_clk,       // system clock, 125 MHz
    input  wire logic                     rst,           // async reset, active high
    input  wire logic                     vdd_ok,        // supply good, async pin
    input  wire logic                     rst_pin_n,     // external reset pin, async
    input  wire rst_boot_pkg::reset_req_t src_req,       // internal reset requests
    input  wire logic [7:0]               src_enable,    // per-source enable, por and pin bits ignored
    input  wire logic [7:0]               flash_rdata,   // flash read data
    output logic                          flash_rd,      // flash read strobe
    output logic [15:0]                   flash_addr,    // flash read address
    output logic                          flash_erase_ok, // last page erasable
    output logic                          core_halt,     // stop instruction execution
    output logic                          regs_rst,      // force registers to defaults
    output logic                          pins_rst,      // force pins to defaults
    output rst_boot_pkg::start_info_t     start,         // start vector for the core
    output logic [7:0]                    last_cause     // sources of last reset
);
    import rst_boot_pkg::*;

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    // carried as fault levels (high = reset wanted): the synchroniser clears to 0,
    // so a flop reset value never looks like a low pin just after release
    logic [1:0] pins_s;

    reset_sync #(.WIDTH(2)) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({~vdd_ok, ~rst_pin_n}),
        .sync_out (pins_s)
    );

    // ------------------------------------------------------------
    // reset request collection
    // ------------------------------------------------------------
    logic [7:0] req_vec;
    logic       any_req;

    always_comb begin
        req_vec = src_req & src_enable;
        req_vec[`SRC_POR]  = src_req.por;
        req_vec[`SRC_PIN]  = pins_s[0];
        req_vec[`SRC_VMON] = pins_s[1] || req_vec[`SRC_VMON];
        any_req = |req_vec;
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    seq_state_t  state, next_state;
    logic [3:0]  lat_cnt, next_lat_cnt;
    logic [7:0]  cause, next_cause;
    logic        rd, next_rd;
    logic        halt, next_halt;
    start_info_t st, next_st;

    always_comb begin
        next_state   = state;
        next_lat_cnt = lat_cnt;
        next_cause   = cause;
        next_rd      = 1'b0;
        next_halt    = halt;
        next_st      = st;
        if (any_req) begin
            // any request wins over the sequence in flight
            next_state   = ST_IN_RESET;
            next_halt    = 1'b1;
            next_st      = '0;
            next_cause   = req_vec;
            next_lat_cnt = '0;
        end else begin
            unique case (state)
                ST_IN_RESET: begin
                    next_state = ST_MARKER_REQ;
                end
                ST_MARKER_REQ: begin
                    next_rd      = 1'b1;
                    next_lat_cnt = READ_LAT;
                    next_state   = ST_MARKER_WAIT;
                end
                ST_MARKER_WAIT: begin
                    if (lat_cnt > 4'h1) begin
                        next_lat_cnt = lat_cnt - 4'h1;
                    end else begin
                        next_state  = ST_RUN;
                        next_halt   = 1'b0;
                        next_st.valid = 1'b1;
                        if (flash_rdata == `BOOT_MARKER_PRESENT) begin
                            next_st.boot_sel = 1'b1;
                            next_st.vector   = BOOT_VECTOR;
                        end else begin
                            next_st.boot_sel = 1'b0;
                            next_st.vector   = `RESET_VECTOR;
                        end
                    end
                end
                ST_RUN: begin
                    next_state = ST_RUN;
                end
                default: begin
                    next_state = ST_IN_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state   <= ST_IN_RESET;
            lat_cnt <= '0;
            cause   <= `CAUSE_AFTER_RST;
            rd      <= 1'b0;
            halt    <= 1'b1;
            st      <= '0;
        end else begin
            state   <= next_state;
            lat_cnt <= next_lat_cnt;
            cause   <= next_cause;
            rd      <= next_rd;
            halt    <= next_halt;
            st      <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    logic [15:0] next_flash_addr;
    logic        next_flash_erase_ok;

    // address and erase permission never move; kept as flops so the
    // flash side sees clean levels straight out of reset
    always_comb begin
        next_flash_addr     = MARKER_ADDR;
        next_flash_erase_ok = 1'b1;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flash_addr     <= MARKER_ADDR;
            flash_erase_ok <= 1'b1;
        end else begin
            flash_addr     <= next_flash_addr;
            flash_erase_ok <= next_flash_erase_ok;
        end
    end

    assign flash_rd   = rd;
    assign core_halt  = halt;
    assign regs_rst   = halt;
    assign pins_rst   = halt;
    assign start      = st;
    assign last_cause = cause;

    // ------------------------------------------------------------
    // assertion helpers
    // ------------------------------------------------------------
    // cycles since the last request dropped, saturating, so the exit time
    // is checked on a counter instead of a long repetition
    logic [3:0] quiet_cnt, next_quiet_cnt;
    logic [7:0] marker_seen, next_marker_seen;

    always_comb begin
        next_quiet_cnt   = quiet_cnt;
        next_marker_seen = marker_seen;
        if (any_req) begin
            next_quiet_cnt = '0;
        end else if (quiet_cnt != '1) begin
            next_quiet_cnt = quiet_cnt + 4'h1;
        end
        // independent copy of the byte at the decision edge
        if (state == ST_MARKER_WAIT && lat_cnt <= 4'h1) begin
            next_marker_seen = flash_rdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            quiet_cnt   <= '0;
            marker_seen <= '0;
        end else begin
            quiet_cnt   <= next_quiet_cnt;
            marker_seen <= next_marker_seen;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_req_halts_core: assert property (any_req |=> core_halt && !start.valid)
        else $error("reset request did not halt the core");
    a_halt_forces_all: assert property (core_halt |-> regs_rst && pins_rst)
        else $error("registers or pins not forced in reset");
    a_marker_read_first: assert property ($rose(start.valid) |-> $past(flash_rd, READ_LAT))
        else $error("start without marker read");
    a_boot_vector_sel: assert property (
        state == ST_MARKER_WAIT && lat_cnt == 4'h1 && !any_req
            && flash_rdata == `BOOT_MARKER_PRESENT
            |=> start.boot_sel && start.vector == BOOT_VECTOR)
        else $error("marker present but boot vector not chosen");
    a_app_vector_sel: assert property (
        state == ST_MARKER_WAIT && lat_cnt == 4'h1 && !any_req
            && flash_rdata != `BOOT_MARKER_PRESENT
            |=> !start.boot_sel && start.vector == `RESET_VECTOR)
        else $error("marker absent but reset vector not chosen");
    a_release_timing: assert property (
        !any_req && state == ST_IN_RESET ##1 !any_req[*4] |-> ##0 !core_halt)
        else $error("exit from reset took the wrong number of cycles");
    a_pin_reset: assert property (pins_s[0] |=> core_halt)
        else $error("reset pin did not force reset");
    a_erase_allowed: assert property (flash_erase_ok)
        else $error("boot page not erasable");

    a_supply_reset: assert property (pins_s[1] |=> core_halt)
        else $error("low supply did not force reset");

    a_por_always: assert property (src_req.por |=> core_halt)
        else $error("power-on request did not force reset");

    a_cause_latched: assert property (any_req |=> last_cause == $past(req_vec))
        else $error("reset cause not captured");

    a_halt_no_start: assert property (core_halt |-> !start.valid)
        else $error("start vector valid while halted");

    a_run_has_start: assert property (!core_halt |-> start.valid)
        else $error("core running without a start vector");

    a_req_clears_start: assert property (any_req |=> start == '0)
        else $error("reset request left a start vector");

    a_rd_one_cycle: assert property (flash_rd |=> !flash_rd)
        else $error("marker read strobe longer than one cycle");

    a_rd_in_wait: assert property (flash_rd |-> state == ST_MARKER_WAIT)
        else $error("marker read outside the read window");

    a_addr_marker: assert property (flash_addr == MARKER_ADDR)
        else $error("flash address not on the marker byte");

    a_exit_halted: assert property (quiet_cnt < READ_LAT + 4'h2 |-> core_halt)
        else $error("core released before the marker was read");

    a_exit_count: assert property (quiet_cnt == READ_LAT + 4'h2 |-> !core_halt)
        else $error("core not released after the marker read");

    a_vector_marker: assert property (
        $rose(start.valid) |-> start.boot_sel == (marker_seen == `BOOT_MARKER_PRESENT))
        else $error("boot selection does not follow the marker byte");

    a_boot_vec_used: assert property (start.boot_sel |-> start.vector == BOOT_VECTOR)
        else $error("boot selected with a wrong vector");

    a_app_vec_zero: assert property (
        start.valid && !start.boot_sel |-> start.vector == `RESET_VECTOR)
        else $error("application start not at the reset vector");

    a_run_holds: assert property (state == ST_RUN && !any_req |=> $stable(start))
        else $error("start vector changed while running");

    c_boot_start: cover property ($rose(start.valid) && start.boot_sel);
    c_app_start:  cover property ($rose(start.valid) && !start.boot_sel);
    c_wdt_reset:  cover property (state == ST_RUN && src_req.wdt_ovf && src_enable[`SRC_WDT]);
    c_abort_read: cover property (state == ST_MARKER_WAIT && any_req);
    c_pin_reset:  cover property (state == ST_RUN && pins_s[0]);
endmodule

// ---- testbench/reset_boot_vector_select_tb.sv ----
// self-checking bench for the reset sequencer and start vector selection
`include "rst_boot_map.svh"

module reset_boot_vector_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rst_boot_pkg::*;

    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    logic        ref_clk;
    logic        rst;
    logic        vdd_ok;
    logic        rst_pin_n;
    reset_req_t  src_req;
    logic [7:0]  src_enable;
    logic [7:0]  flash_rdata;
    logic        flash_rd;
    logic [15:0] flash_addr;
    logic        flash_erase_ok;
    logic        core_halt;
    logic        regs_rst;
    logic        pins_rst;
    start_info_t start;
    logic [7:0]  last_cause;
    int          num_errors;
    int          total_checks;

    reset_boot_vector_select i_reset_boot_vector_select (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .vdd_ok         (vdd_ok),
        .rst_pin_n      (rst_pin_n),
        .src_req        (src_req),
        .src_enable     (src_enable),
        .flash_rdata    (flash_rdata),
        .flash_rd       (flash_rd),
        .flash_addr     (flash_addr),
        .flash_erase_ok (flash_erase_ok),
        .core_halt      (core_halt),
        .regs_rst       (regs_rst),
        .pins_rst       (pins_rst),
        .start          (start),
        .last_cause     (last_cause)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // wrong byte on the data lines until the read strobe, so an early sample shows
    task automatic boot_run(input logic [7:0] marker, input logic [15:0] vec, input logic sel);
        int n;
        int rd;
        n = 0;
        rd = 0;
        flash_rdata = ~marker;
        while (start.valid !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
            if (flash_rd === 1'b1) begin
                rd++;
                check(flash_addr, `MARKER_ADDR);
                flash_rdata = marker;
            end
        end
        if (n >= 60) begin
            num_errors++;
            end_sim();
        end
        check(rd, 1);
        check(start.vector, vec);
        check(start.boot_sel, sel);
        check({core_halt, regs_rst, pins_rst}, 3'h0);
        check(flash_erase_ok, 1'b1);
        flash_rdata = ~marker;
    endtask

    task automatic expect_reset(input int bit_idx);
        repeat (4) @(negedge ref_clk);
        check({core_halt, regs_rst, pins_rst}, 3'h7);
        check(start.valid, 1'b0);
        check(last_cause[bit_idx], 1'b1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic sc_internal_sources();
        for (int k = 2; k < 8; k++) begin
            src_req = reset_req_t'(8'h01 << k);
            expect_reset(k);
            src_req = '0;
            if (k[0]) boot_run(8'hA5, `BOOT_VECTOR_DEFAULT, 1'b1);
            else boot_run(8'h5A, 16'h0000, 1'b0);
        end
    endtask

    task automatic sc_pin_and_supply();
        rst_pin_n = 1'b0;
        expect_reset(1);
        rst_pin_n = 1'b1;
        boot_run(8'hA5, `BOOT_VECTOR_DEFAULT, 1'b1);
        vdd_ok = 1'b0;
        expect_reset(4);
        vdd_ok = 1'b1;
        boot_run(8'hA4, 16'h0000, 1'b0);
    endtask

    // values other than the marker (neighbours, 0x00, 0xFF) must not select the boot program; an
    // integrator who disables the loader leaves one of these in flash
    task automatic sc_marker_values();
        logic [7:0] vals [5] = '{8'h00, 8'hA4, 8'hA6, 8'hFF, 8'h25};
        foreach (vals[i]) begin
            src_req = reset_req_t'(8'h08);
            expect_reset(3);
            src_req = '0;
            boot_run(vals[i], 16'h0000, 1'b0);
        end
    endtask

    task automatic sc_disabled_source();
        src_enable = 8'hF7;
        src_req = reset_req_t'(8'h08);
        repeat (4) @(negedge ref_clk);
        check({core_halt, start.valid}, 2'h1);
        src_req = '0;
        src_enable = 8'hFF;
        @(negedge ref_clk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        vdd_ok = 1'b1;
        rst_pin_n = 1'b1;
        src_req = '0;
        src_enable = 8'hFF;
        flash_rdata = 8'h00;
        num_errors = 0;
        total_checks = 0;
        repeat (5) @(negedge ref_clk);
        check({core_halt, regs_rst, pins_rst, start.valid}, 4'hE);
        rst = 1'b0;
        check(last_cause, 8'h01);
        boot_run(8'hA5, `BOOT_VECTOR_DEFAULT, 1'b1);
        sc_disabled_source();
        sc_internal_sources();
        sc_pin_and_supply();
        sc_marker_values();
        end_sim();
    end
endmodule
